// File: cidec_defs.svh
// Purpose: Constants for the compact immediate/memory-address instruction unit
// Assumes: 16-bit compressed encodings, 32-bit data path, 25 MHz clock
// Notes: Offsets, encodings, register port map and reset values only; types live in cidec_pkg
//
// Operation
// - Halfword store writes low 16 bits of dest at base plus offset.
// - Halfword load fills low half of dest, upper sixteen bits cleared.
// - Halfword offset is five-bit field shifted left one, bit 0 zero.
// - Halfword transfers use only low registers zero to seven.
// - Stack store writes full dest word at stack pointer plus word offset.
// - Stack load reads word at stack pointer plus up to 255 words.
// - Stack offset is eight-bit field shifted left two, low bits zero.
// - Load-address with select 0 writes program counter plus constant to dest.
// - Load-address with select 1 writes stack pointer plus constant to dest.
// - Load-address constant is eight-bit field shifted left two.
// - Program counter operand has bit 1 forced to zero before adding.
// - Program counter operand is instruction address plus four.
// - Load-address leaves the four condition flags unchanged.
// - Stack adjust adds offset when negate is 0, subtracts when 1.
// - Stack adjust magnitude is seven-bit field shifted left two, up to 508.
// - Stack adjust changes no condition flag.
// - Each instruction takes the cycles of its full-width equivalent.
`ifndef CIDEC_DEFS_SVH
`define CIDEC_DEFS_SVH

// ----------------------------------------
// Opcode prefixes
// ----------------------------------------
`define CIDEC_OP_HALF 4'h8
`define CIDEC_OP_STACK 4'h9
`define CIDEC_OP_LDADDR 4'hA
`define CIDEC_OP_SPADJ 8'hB0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CIDEC_LSEL_BIT 11
`define CIDEC_SPADJ_NEG_BIT 7
`define CIDEC_PC_MASK 32'hFFFF_FFFD
`define CIDEC_PC_AHEAD 32'h0000_0004

// ----------------------------------------
// Register port map
// ----------------------------------------
`define CIDEC_ADDR_SP 4'h8
`define CIDEC_ADDR_FLAGS 4'h9
`define CIDEC_ADDR_STATUS 4'hA
`define CIDEC_FLAGS_RESET 4'h0
`define CIDEC_SP_RESET 32'h0000_0000

`endif

// File: cidec_pkg.sv
// Purpose: Shared types for the compact instruction unit
// Assumes: Included defs supply every number
// Notes: No constants here, only types
`default_nettype none
package cidec_pkg;

  typedef enum logic [1:0] {
    CIDEC_IDLE = 2'b00,
    CIDEC_MEM = 2'b01,
    CIDEC_LDWB = 2'b10
  } cidec_state_t;

  typedef enum logic [2:0] {
    CIDEC_NONE = 3'b000,
    CIDEC_HALF = 3'b001,
    CIDEC_STACK = 3'b010,
    CIDEC_LDADDR = 3'b011,
    CIDEC_SPADJ = 3'b100
  } cidec_op_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic half;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cidec_mem_req_t;

endpackage
`default_nettype wire

// File: cidec_agu.sv
// Purpose: Address and operand adder
// Assumes: Unsigned operands, wraps modulo two to the width
// Notes: Shared by every instruction of the group
`timescale 1ns/10ps
`default_nettype none
module cidec_agu #(
  parameter int WIDTH = 32
) (
  // Operands
  input wire logic [WIDTH-1:0] i_base,
  input wire logic [WIDTH-1:0] i_offset,
  input wire logic i_subtract,
  // Result
  output logic [WIDTH-1:0] o_sum
);

  always_comb begin
    if (i_subtract) begin
      o_sum = i_base - i_offset;
    end else begin
      o_sum = i_base + i_offset;
    end
  end

endmodule // cidec_agu
`default_nettype wire

// File: cidec_top.sv
// Purpose: Decode and execute the halfword, stack, load-address and stack-adjust group
// Assumes: Memory system on the same clock answers each request with one ack pulse
// Notes: Registers zero to seven, stack pointer and flags live here
`timescale 1ns/10ps
`default_nettype none
`include "cidec_defs.svh"
module cidec_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Instruction issue
  input wire logic i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire logic [31:0] i_instr_addr,
  output logic o_instr_ready,
  output logic o_done,
  output logic o_illegal,
  // Memory access
  output cidec_pkg::cidec_mem_req_t o_mem,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  // Register port
  input wire logic [3:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // Condition flags
  output logic [3:0] o_flags
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  cidec_pkg::cidec_op_t op;
  logic load_select_bit;
  logic stack_base_select;
  logic negate_flag;
  logic [2:0] dest_reg;
  logic [2:0] base_reg;
  logic [4:0] offset_field_five;
  logic [7:0] word_offset_field;
  logic [6:0] signed_sp_offset_field;
  logic [31:0] half_offset;
  logic [31:0] word_offset;
  logic [31:0] spadj_offset;

  always_comb begin
    op = cidec_pkg::CIDEC_NONE;
    if (i_instr[15:12] == `CIDEC_OP_HALF) begin
      op = cidec_pkg::CIDEC_HALF;
    end else if (i_instr[15:12] == `CIDEC_OP_STACK) begin
      op = cidec_pkg::CIDEC_STACK;
    end else if (i_instr[15:12] == `CIDEC_OP_LDADDR) begin
      op = cidec_pkg::CIDEC_LDADDR;
    end else if (i_instr[15:8] == `CIDEC_OP_SPADJ) begin
      op = cidec_pkg::CIDEC_SPADJ;
    end
  end

  assign load_select_bit = i_instr[`CIDEC_LSEL_BIT];
  assign stack_base_select = i_instr[`CIDEC_LSEL_BIT];
  assign negate_flag = i_instr[`CIDEC_SPADJ_NEG_BIT];
  // Only three bits, so high registers cannot be named
  assign dest_reg = (op == cidec_pkg::CIDEC_HALF) ? i_instr[2:0] : i_instr[10:8];
  assign base_reg = i_instr[5:3];
  assign offset_field_five = i_instr[10:6];
  assign word_offset_field = i_instr[7:0];
  assign signed_sp_offset_field = i_instr[6:0];
  assign half_offset = {26'h000_0000, offset_field_five, 1'b0};
  assign word_offset = {22'h00_0000, word_offset_field, 2'b00};
  assign spadj_offset = {23'h00_0000, signed_sp_offset_field, 2'b00};

  // ----------------------------------------
  // State
  // ----------------------------------------
  cidec_pkg::cidec_state_t state;
  cidec_pkg::cidec_state_t next_state;
  logic [31:0] regs [0:7];
  logic [31:0] next_regs [0:7];
  logic [31:0] sp;
  logic [31:0] next_sp;
  logic [3:0] flags;
  logic [3:0] next_flags;
  logic [2:0] ld_dest;
  logic [2:0] next_ld_dest;
  logic ld_half;
  logic next_ld_half;
  logic [31:0] ld_data;
  logic [31:0] next_ld_data;
  logic done;
  logic next_done;
  logic illegal;
  logic next_illegal;
  cidec_pkg::cidec_mem_req_t mem;
  cidec_pkg::cidec_mem_req_t next_mem;
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  // ----------------------------------------
  // Operand selection and adder
  // ----------------------------------------
  logic [31:0] pc_ahead;
  logic [31:0] pc_operand;
  logic [31:0] agu_base;
  logic [31:0] agu_offset;
  logic agu_sub;
  logic [31:0] agu_sum;

  // Prefetch puts the counter one word ahead, then bit 1 reads as zero
  assign pc_ahead = i_instr_addr + `CIDEC_PC_AHEAD;
  assign pc_operand = pc_ahead & `CIDEC_PC_MASK;

  always_comb begin
    agu_base = regs[base_reg];
    agu_offset = half_offset;
    agu_sub = 1'b0;
    unique case (op)
      cidec_pkg::CIDEC_HALF: begin
        agu_base = regs[base_reg];
        agu_offset = half_offset;
      end
      cidec_pkg::CIDEC_STACK: begin
        agu_base = sp;
        agu_offset = word_offset;
      end
      cidec_pkg::CIDEC_LDADDR: begin
        agu_base = stack_base_select ? sp : pc_operand;
        agu_offset = word_offset;
      end
      cidec_pkg::CIDEC_SPADJ: begin
        agu_base = sp;
        agu_offset = spadj_offset;
        agu_sub = negate_flag;
      end
      cidec_pkg::CIDEC_NONE: begin
        agu_base = regs[base_reg];
      end
    endcase
  end

  cidec_agu #(
    .WIDTH(32)
  ) u_agu (
    .i_base(agu_base),
    .i_offset(agu_offset),
    .i_subtract(agu_sub),
    .o_sum(agu_sum)
  );

  // ----------------------------------------
  // Register port decode
  // ----------------------------------------
  // One decode feeds write and read paths, so the two maps cannot drift apart
  logic sel_gpr;
  logic sel_sp;
  logic sel_flags;
  logic sel_status;
  logic sw_gpr_wr;
  logic sw_sp_wr;
  logic sw_flags_wr;

  always_comb begin
    sel_gpr = 1'b0;
    sel_sp = 1'b0;
    sel_flags = 1'b0;
    sel_status = 1'b0;
    if (i_reg_addr[3] == 1'b0) begin
      sel_gpr = 1'b1;
    end else if (i_reg_addr == `CIDEC_ADDR_SP) begin
      sel_sp = 1'b1;
    end else if (i_reg_addr == `CIDEC_ADDR_FLAGS) begin
      sel_flags = 1'b1;
    end else if (i_reg_addr == `CIDEC_ADDR_STATUS) begin
      sel_status = 1'b1;
    end
  end

  assign sw_gpr_wr = i_reg_wr && sel_gpr;
  assign sw_sp_wr = i_reg_wr && sel_sp;
  assign sw_flags_wr = i_reg_wr && sel_flags;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Store: issue plus memory cycle; load adds one internal cycle; add is one cycle
  logic take;
  assign o_instr_ready = (state == cidec_pkg::CIDEC_IDLE);
  assign take = i_instr_valid && o_instr_ready;

  always_comb begin
    next_state = state;
    next_mem = mem;
    next_ld_dest = ld_dest;
    next_ld_half = ld_half;
    next_ld_data = ld_data;
    next_done = 1'b0;
    next_illegal = 1'b0;
    next_sp = sp;
    next_flags = flags;
    for (int i = 0; i < 8; i++) begin
      next_regs[i] = regs[i];
    end
    // Software writes lose to a same-cycle writeback, applied first
    if (sw_gpr_wr) begin
      next_regs[i_reg_addr[2:0]] = i_reg_wdata;
    end
    if (sw_sp_wr) begin
      next_sp = i_reg_wdata;
    end
    if (sw_flags_wr) begin
      next_flags = i_reg_wdata[3:0];
    end
    unique case (state)
      cidec_pkg::CIDEC_IDLE: begin
        if (take) begin
          unique case (op)
            cidec_pkg::CIDEC_HALF,
            cidec_pkg::CIDEC_STACK: begin
              next_mem.valid = 1'b1;
              next_mem.write = ~load_select_bit;
              next_mem.half = (op == cidec_pkg::CIDEC_HALF);
              next_mem.addr = agu_sum;
              if (op == cidec_pkg::CIDEC_HALF) begin
                next_mem.wdata = {16'h0000, regs[dest_reg][15:0]};
              end else begin
                next_mem.wdata = regs[dest_reg];
              end
              next_ld_dest = dest_reg;
              next_ld_half = (op == cidec_pkg::CIDEC_HALF);
              next_state = cidec_pkg::CIDEC_MEM;
            end
            cidec_pkg::CIDEC_LDADDR: begin
              // Flags left alone
              next_regs[dest_reg] = agu_sum;
              next_done = 1'b1;
            end
            cidec_pkg::CIDEC_SPADJ: begin
              // Flags left alone
              next_sp = agu_sum;
              next_done = 1'b1;
            end
            cidec_pkg::CIDEC_NONE: begin
              next_illegal = 1'b1;
            end
          endcase
        end
      end
      cidec_pkg::CIDEC_MEM: begin
        if (i_mem_ack) begin
          next_mem.valid = 1'b0;
          if (mem.write) begin
            next_done = 1'b1;
            next_state = cidec_pkg::CIDEC_IDLE;
          end else begin
            if (ld_half) begin
              next_ld_data = {16'h0000, i_mem_rdata[15:0]};
            end else begin
              next_ld_data = i_mem_rdata;
            end
            next_state = cidec_pkg::CIDEC_LDWB;
          end
        end
      end
      cidec_pkg::CIDEC_LDWB: begin
        // Internal cycle of a load writes the register
        next_regs[ld_dest] = ld_data;
        next_done = 1'b1;
        next_state = cidec_pkg::CIDEC_IDLE;
      end
      default: begin
        next_state = cidec_pkg::CIDEC_IDLE;
        next_mem.valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= cidec_pkg::CIDEC_IDLE;
      mem <= '0;
      ld_dest <= 3'h0;
      ld_half <= 1'b0;
      ld_data <= 32'h0000_0000;
      done <= 1'b0;
      illegal <= 1'b0;
      sp <= `CIDEC_SP_RESET;
      flags <= `CIDEC_FLAGS_RESET;
      for (int i = 0; i < 8; i++) begin
        regs[i] <= 32'h0000_0000;
      end
    end else begin
      state <= next_state;
      mem <= next_mem;
      ld_dest <= next_ld_dest;
      ld_half <= next_ld_half;
      ld_data <= next_ld_data;
      done <= next_done;
      illegal <= next_illegal;
      sp <= next_sp;
      flags <= next_flags;
      for (int i = 0; i < 8; i++) begin
        regs[i] <= next_regs[i];
      end
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  // Unmapped addresses read zero
  always_comb begin
    next_rdata = rdata;
    if (i_reg_rd) begin
      if (sel_gpr) begin
        next_rdata = regs[i_reg_addr[2:0]];
      end else if (sel_sp) begin
        next_rdata = sp;
      end else if (sel_flags) begin
        next_rdata = {28'h000_0000, flags};
      end else if (sel_status) begin
        // Status shows the sequencer, so software can spot a stalled access
        next_rdata = {30'h0000_0000, state};
      end else begin
        next_rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_reg_rdata = rdata;
  assign o_mem = mem;
  assign o_done = done;
  assign o_illegal = illegal;
  assign o_flags = flags;

endmodule // cidec_top
`default_nettype wire

// File: cidec_checker.sv
// Purpose: Port assertions for cidec_top
// Assumes: One clock, async active-low reset
// Notes: Sees only top-level ports
`timescale 1ns/10ps
`default_nettype none
module cidec_checker (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Watched ports
  input wire logic i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire logic o_instr_ready,
  input wire logic o_done,
  input wire cidec_pkg::cidec_mem_req_t o_mem,
  input wire logic i_mem_ack,
  input wire logic [3:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [3:0] o_flags
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic tk;
  assign tk = i_instr_valid && o_instr_ready;
  property p_flags; !$past(i_reg_wr && i_reg_addr == 4'h9) |-> $stable(o_flags); endproperty
  a_flags: assert property (p_flags)
    else $error("flags moved without a register write");
  property p_hwdata; o_mem.valid && o_mem.half && o_mem.write |-> o_mem.wdata[31:16] == 16'h0000; endproperty
  a_hwdata: assert property (p_hwdata)
    else $error("halfword store data has upper bits set");
  property p_hold; o_mem.valid && !i_mem_ack |=> o_mem.valid && $stable(o_mem); endproperty
  a_hold: assert property (p_hold)
    else $error("request changed before ack");
  property p_st; o_mem.valid && o_mem.write && i_mem_ack |=> o_done && !o_mem.valid; endproperty
  a_st: assert property (p_st)
    else $error("store not done one cycle after ack");
  property p_ld; o_mem.valid && !o_mem.write && i_mem_ack |=> !o_done ##1 o_done; endproperty
  a_ld: assert property (p_ld)
    else $error("load not done two cycles after ack");
  property p_quick; tk && (i_instr[15:12] == 4'hA || i_instr[15:8] == 8'hB0) |=> o_done && !o_mem.valid; endproperty
  a_quick: assert property (p_quick)
    else $error("address or stack adjust not done in one cycle");
  property p_half; tk && i_instr[15:12] == 4'h8 |=> o_mem.valid && o_mem.half && o_mem.write != $past(i_instr[11]); endproperty
  a_half: assert property (p_half)
    else $error("halfword request wrong");
  property p_stk; tk && i_instr[15:12] == 4'h9 |=> o_mem.valid && !o_mem.half && o_mem.write != $past(i_instr[11]); endproperty
  a_stk: assert property (p_stk)
    else $error("stack request wrong");
endmodule // cidec_checker

bind cidec_top cidec_checker u_chk (.i_clk, .i_resetn, .i_instr_valid, .i_instr, .o_instr_ready, .o_done,
  .o_mem, .i_mem_ack, .i_reg_addr, .i_reg_wr, .o_flags);
`default_nettype wire

// File: cidec_mem_model.sv
// Purpose: Memory serving the unit's requests
// Assumes: i_wait extra cycles before each ack
// Notes: Idle read data toggles, never holds
`timescale 1ns/10ps
`default_nettype none
module cidec_mem_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Request side
  input wire cidec_pkg::cidec_mem_req_t i_mem,
  input wire logic [1:0] i_wait,
  output logic o_ack,
  output logic [31:0] o_rdata
);
  // ----------------------------------------
  // Storage and answer
  // ----------------------------------------
  logic [31:0] mem [0:63];
  logic [1:0] cnt;
  logic [31:0] w;
  logic [5:0] ix;
  assign ix = i_mem.addr[7:2];
  assign w = mem[ix];
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ack <= 1'b0;
      cnt <= 2'h0;
      o_rdata <= 32'h0000_0000;
    end else begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_mem.valid && !o_ack) begin
        cnt <= cnt + 2'h1;
        if (cnt == i_wait) begin
          cnt <= 2'h0;
          o_ack <= 1'b1;
          // Upper half is junk so zero-fill is really exercised
          if (i_mem.half) o_rdata <= i_mem.addr[1] ? {~w[31:16], w[31:16]} : {~w[15:0], w[15:0]};
          else o_rdata <= w;
          if (i_mem.write && !i_mem.half) mem[ix] <= i_mem.wdata;
          if (i_mem.write && i_mem.half && i_mem.addr[1]) mem[ix][31:16] <= i_mem.wdata[15:0];
          if (i_mem.write && i_mem.half && !i_mem.addr[1]) mem[ix][15:0] <= i_mem.wdata[15:0];
        end
      end
    end
  end
endmodule // cidec_mem_model
`default_nettype wire

// File: cidec_top_tb.sv
// Purpose: Self-checking bench for cidec_top
// Assumes: Latencies as given in the hand-over contract
// Notes: Memory model adds one registered cycle per ack
`timescale 1ns/10ps
`default_nettype none
module cidec_top_tb;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic vld = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] ins = 16'h0000;
  logic [31:0] iad = 32'h0000_0000;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] radr = 4'h0;
  logic [1:0] wt = 2'h0;
  logic rdy, done, ill, ack, gi;
  logic [31:0] mrd, rdat;
  logic [3:0] flg;
  cidec_pkg::cidec_mem_req_t mreq, seen;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  always #20 i_clk = ~i_clk;
  cidec_top dut (.i_clk, .i_resetn, .i_instr_valid(vld), .i_instr(ins), .i_instr_addr(iad), .o_instr_ready(rdy),
    .o_done(done), .o_illegal(ill), .o_mem(mreq), .i_mem_ack(ack), .i_mem_rdata(mrd), .i_reg_addr(radr),
    .i_reg_wdata(wdat), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat), .o_flags(flg));
  cidec_mem_model mem (.i_clk, .i_resetn, .i_mem(mreq), .i_wait(wt), .o_ack(ack), .o_rdata(mrd));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [31:0] rv(input int i);
    return 32'h9876_0000 + 32'(i) * 32'h0000_1041;
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    wr <= 1'b1;
    radr <= a;
    wdat <= d;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask
  task rreg(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_clk);
    rd <= 1'b1;
    radr <= a;
    @(posedge i_clk);
    rd <= 1'b0;
    #1 chk(rdat, e);
  endtask
  task run(input logic [15:0] c, input logic [31:0] a, input int w, input int lat, input logic il);
    @(posedge i_clk);
    vld <= 1'b1;
    ins <= c;
    iad <= a;
    wt <= 2'(w);
    do @(posedge i_clk); while (rdy !== 1'b1);
    vld <= 1'b0;
    n = 0;
    gi = 1'b0;
    do begin
      @(posedge i_clk);
      n++;
      if (mreq.valid) seen = mreq;
      if (ill === 1'b1) gi = 1'b1;
    end while (done !== 1'b1 && gi !== 1'b1 && n < 20);
    chk(32'(n), 32'(lat));
    chk({31'h0, gi}, {31'h0, il});
  endtask
  task finish_test();
    $display("Checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      finish_test();
    end
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    rreg(4'h8, 32'h0000_0000);
    for (int i = 0; i < 8; i++) wreg(4'(i), rv(i));
    wreg(4'h8, 32'h0000_0100);
    wreg(4'h9, 32'h0000_000A);
    wreg(4'hF, 32'hFFFF_FFFF);
    rreg(4'hF, 32'h0000_0000);
    run(16'h80CA, 32'h0, 0, 3, 1'b0);
    chk(seen.addr, rv(1) + 32'h0000_0006);
    chk(seen.wdata, rv(2) & 32'h0000_FFFF);
    run(16'h88CF, 32'h0, 2, 6, 1'b0);
    rreg(4'h7, rv(2) & 32'h0000_FFFF);
    run(16'h8053, 32'h0, 0, 3, 1'b0);
    chk(seen.addr, rv(2) + 32'h0000_0002);
    chk(seen.wdata, rv(3) & 32'h0000_FFFF);
    run(16'h8850, 32'h0, 1, 5, 1'b0);
    rreg(4'h0, rv(3) & 32'h0000_FFFF);
    run(16'h93FF, 32'h0, 1, 4, 1'b0);
    chk(seen.addr, 32'h0000_04FC);
    chk(seen.wdata, rv(3));
    run(16'h9CFF, 32'h0, 0, 4, 1'b0);
    rreg(4'h4, rv(3));
    run(16'hA58F, 32'h0000_1002, 0, 1, 1'b0);
    rreg(4'h5, 32'h0000_1240);
    run(16'hAE35, 32'h0, 0, 1, 1'b0);
    rreg(4'h6, 32'h0000_01D4);
    run(16'hB07F, 32'h0, 0, 1, 1'b0);
    run(16'hB09A, 32'h0, 0, 1, 1'b0);
    rreg(4'h8, 32'h0000_0294);
    run(16'hB100, 32'h0, 0, 1, 1'b1);
    run(16'hC000, 32'h0, 0, 1, 1'b1);
    chk({28'h0, flg}, 32'h0000_000A);
    rreg(4'h9, 32'h0000_000A);
    rreg(4'hA, 32'h0000_0000);
    finish_test();
  end
endmodule // cidec_top_tb
`default_nettype wire
